// ### sim/test_erc_top.sv
// Purpose: self-checking bench for the run-length checker, register port and verdict
// Assumes: one clock, samples driven by the bench as the generator would
// Notes:   one fixed window exercises every length; limits steer pass or fail
`timescale 1ns/100ps

module test_erc_top
  import erc_pkg::*;
;
  // clock and reset
  logic           mclk;
  logic           arst_n;
  // register port
  logic [7:0]     reg_addr;
  logic [31:0]    reg_wdata;
  logic           reg_wr;
  logic           reg_rd;
  logic [31:0]    reg_rdata;
  // samples and verdict
  erc_sample_type samp;
  logic           check_pass;
  logic           retry_req;
  logic           gen_error;
  logic           busy;
  // bookkeeping
  int             err_count;
  int             num_checks;
  logic [31:0]    rd_val;

  // edge runs 000 and 1111 must stay uncounted; inner runs hold one ones run and one zeros run of each length
  localparam logic [34:0] SEQ = 35'b000_11_000_1111_00000_111_00_11111_0000_1111;
  localparam logic [31:0] PROGRAM_MODE_SELECT = 32'h0001_0000;                // program mode only
  localparam logic [31:0] RSTD = 32'h0001_0040;                // program mode, restore
  localparam logic [31:0] DIS  = 32'h0001_0020;                // program mode, disable
  localparam logic [7:0]  OFS [4] = '{RUN2_OFS, RUN3_OFS, RUN4_OFS, RUN5_OFS};
  localparam logic [13:0] RRNG [4] = '{LEN2_RNG_RST, LEN3_RNG_RST, LEN4_RNG_RST,
                                       LEN5_RNG_RST};
  localparam logic [13:0] RMAX [4] = '{LEN2_MAX_RST, LEN3_MAX_RST, LEN4_MAX_RST,
                                       LEN5_MAX_RST};
  localparam logic [13:0] DRNG [4] = '{LEN2_RNG_DIS, LEN3_RNG_DIS, LEN4_RNG_DIS,
                                       LEN5_RNG_DIS};
  localparam logic [13:0] DMAX [4] = '{LEN2_MAX_DIS, LEN3_MAX_DIS, LEN4_MAX_DIS,
                                       LEN5_MAX_DIS};

  erc_top i_erc_top (
    .mclk       (mclk),
    .arst_n     (arst_n),
    .reg_addr   (reg_addr),
    .reg_wdata  (reg_wdata),
    .reg_wr     (reg_wr),
    .reg_rd     (reg_rd),
    .reg_rdata  (reg_rdata),
    .samp       (samp),
    .check_pass (check_pass),
    .retry_req  (retry_req),
    .gen_error  (gen_error),
    .busy       (busy)
  );

  //////////////////////////////////////////////////////////////////////////////
  // 25 MHz clock
  initial mclk = 1'b0;
  always #20 mclk = ~mclk;

  // limit word from a range and a maximum field
  function automatic logic [31:0] lim(input logic [13:0] rng, input logic [13:0] max);
    return {2'b00, rng, 2'b00, max};
  endfunction

  // compare and count
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // verdict and end of run
  task automatic print_verdict();
    if (err_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // register port: one-cycle strobes launched just after the edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask

  // read data lives only in the cycle after the strobe, so sample it there
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // read and compare in one call
  task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    check(name, d, exp);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // one sample window; expect 100 pass, 010 retry, 001 error
  task automatic run_win(input string name, input logic [2:0] exp);
    int n;
    @(posedge mclk);
    samp <= 4'b1000;
    @(posedge mclk);
    samp <= 4'b0000;
    #1;
    check("busy", {31'h0, busy}, 32'h1);
    for (int i = 34; i >= 0; i--) begin
      @(posedge mclk);
      samp <= {1'b0, 1'b1, SEQ[i], (i == 0)};
    end
    @(posedge mclk);
    samp <= 4'b0000;
    n = 0;
    // bounded wait, the verdict is due two edges after the last sample
    while ((check_pass | retry_req | gen_error) !== 1'b1 && n < 8) begin
      @(posedge mclk);
      #1;
      n++;
    end
    check(name, {29'h0, check_pass, retry_req, gen_error}, {29'h0, exp});
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // watchdog: the whole sequence needs about 630 cycles
  initial begin
    repeat (6000) @(posedge mclk);
    err_count++;
    print_verdict();
  end

  // main sequence
  initial begin
    err_count  = 0;
    num_checks = 0;
    arst_n     = 1'b0;
    reg_addr   = 8'h00;
    reg_wdata  = 32'h0000_0000;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    samp       = 4'b0000;
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    // limits after reset, seen through program mode
    wr(MAIN_CONTROL_OFS, PROGRAM_MODE_SELECT);
    for (int l = 0; l < 4; l++) rdc("limit reset", OFS[l], lim(RRNG[l], RMAX[l]));
    // written fields are masked to their widths
    wr(RUN3_OFS, 32'hFFFF_FFFF);
    rdc("run3 limit rw", RUN3_OFS, 32'h1FFF_1FFF);
    // disable loads all-ones ranges with maxima one below, restore brings the reset values back
    wr(MAIN_CONTROL_OFS, DIS);
    for (int l = 0; l < 4; l++) rdc("limit disable", OFS[l], lim(DRNG[l], DMAX[l]));
    wr(MAIN_CONTROL_OFS, RSTD);
    for (int l = 0; l < 4; l++) rdc("limit restore", OFS[l], lim(RRNG[l], RMAX[l]));
    // run mode: shared offsets are read-only, unmapped reads give zero
    wr(MAIN_CONTROL_OFS, 32'h0000_0000);
    wr(RUN3_OFS, 32'h0000_0000);
    rdc("run2 in run mode", RUN2_OFS, 32'h0000_0000);
    rdc("unmapped", 8'h40, 32'h0000_0000);
    rdc("retries reset", MISC_CHECK_OFS, 32'h0001_0000);
    wr(MAIN_CONTROL_OFS, PROGRAM_MODE_SELECT);
    rdc("run3 write ignored", RUN3_OFS, lim(RRNG[1], RMAX[1]));
    // narrow limits: two runs per length pass when 0 < total < 5
    for (int l = 0; l < 4; l++) wr(OFS[l], 32'h0005_0005);
    wr(MAIN_CONTROL_OFS, 32'h0000_0000);
    run_win("pass verdict", 3'b100);
    rdc("run3 counts", RUN3_OFS, 32'h0004_0004);
    rdc("run4 counts", RUN4_OFS, 32'h0004_0004);
    rdc("run5 counts", RUN5_OFS, 32'h0004_0004);
    rdc("no retry used", MISC_CHECK_OFS, 32'h0001_0000);
    // each length alone fails at its maximum (c=0) and at max minus range (c=1)
    for (int l = 0; l < 4; l++) begin
      for (int c = 0; c < 2; c++) begin
        wr(MAIN_CONTROL_OFS, PROGRAM_MODE_SELECT);
        wr(OFS[l], (c == 1) ? 32'h0003_0005 : 32'h0002_0002);
        wr(MISC_CHECK_OFS, 32'h0001_0000);
        wr(MAIN_CONTROL_OFS, 32'h0000_0000);
        run_win("retry verdict", 3'b010);
        rdc("retry consumed", MISC_CHECK_OFS, 32'h0000_0000);
        wr(MAIN_CONTROL_OFS, PROGRAM_MODE_SELECT);
        wr(OFS[l], 32'h0005_0005);
      end
    end
    // no retries left: failure becomes an error and the count stays at zero
    wr(RUN3_OFS, 32'h0002_0002);
    wr(MAIN_CONTROL_OFS, 32'h0000_0000);
    run_win("error verdict", 3'b001);
    rdc("retries at zero", MISC_CHECK_OFS, 32'h0000_0000);
    rd(CHECK_RESULT_OFS, rd_val);
    check("error flag", rd_val & 32'h0000_0040, 32'h0000_0040);
    // software raises the count, the next failure retries and decrements it
    wr(MISC_CHECK_OFS, 32'h0003_0000);
    rdc("retries raised", MISC_CHECK_OFS, 32'h0003_0000);
    run_win("retry after raise", 3'b010);
    rdc("retries decremented", MISC_CHECK_OFS, 32'h0002_0000);
    print_verdict();
  end

endmodule

// ### verilog/erc_pkg.sv
// Purpose: shared constants and types for the entropy run-length checker
// Assumes: 32-bit register port, byte addresses, one aligned word per register
// Notes:   limit fields are held at 14 bits and masked to each length's width
package erc_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [7:0] MAIN_CONTROL_OFS = 8'h00;  // mode and limit actions
  localparam logic [7:0] MISC_CHECK_OFS   = 8'h0C;  // retry count
  localparam logic [7:0] CHECK_RESULT_OFS = 8'h10;  // verdict flags
  localparam logic [7:0] RUN2_OFS         = 8'h28;  // length-2 limits
  localparam logic [7:0] RUN3_OFS         = 8'h2C;  // length-3 counts / limits
  localparam logic [7:0] RUN4_OFS         = 8'h30;  // length-4 counts / limits
  localparam logic [7:0] RUN5_OFS         = 8'h34;  // length-5 counts / limits

  // main_control bit positions
  localparam int PROGRAM_MODE_SELECT_BIT    = 16;  // program_mode_select
  localparam int RESTORE_DEFAULTS_BIT = 6;   // restore_defaults, write-one action
  localparam int DIS_ST_BIT  = 5;   // self_test_disable

  // field positions
  localparam int HI_LSB    = 16;  // range field and ones count
  localparam int RETRY_LSB = 16;  // retries_remaining in misc_check_control

  //////////////////////////////////////////////////////////////////////////////
  // values after reset
  localparam logic [3:0]  RETRY_RST   = 4'h1;
  localparam logic [13:0] LEN2_RNG_RST = 14'h0036;
  localparam logic [13:0] LEN2_MAX_RST = 14'h003E;
  localparam logic [13:0] LEN3_RNG_RST = 14'h002D;
  localparam logic [13:0] LEN3_MAX_RST = 14'h0037;
  localparam logic [13:0] LEN4_RNG_RST = 14'h001B;
  localparam logic [13:0] LEN4_MAX_RST = 14'h001A;
  localparam logic [13:0] LEN5_RNG_RST = 14'h0013;
  localparam logic [13:0] LEN5_MAX_RST = 14'h0012;

  // values loaded when self-test is disabled
  localparam logic [13:0] LEN2_RNG_DIS = 14'h3FFF;
  localparam logic [13:0] LEN2_MAX_DIS = 14'h3FFE;
  localparam logic [13:0] LEN3_RNG_DIS = 14'h1FFF;
  localparam logic [13:0] LEN3_MAX_DIS = 14'h1FFE;
  localparam logic [13:0] LEN4_RNG_DIS = 14'h0FFF;
  localparam logic [13:0] LEN4_MAX_DIS = 14'h0FFE;
  localparam logic [13:0] LEN5_RNG_DIS = 14'h07FF;
  localparam logic [13:0] LEN5_MAX_DIS = 14'h07FE;

  // field masks per run length
  localparam logic [13:0] LEN2_MASK = 14'h3FFF;
  localparam logic [13:0] LEN3_MASK = 14'h1FFF;
  localparam logic [13:0] LEN4_MASK = 14'h0FFF;
  localparam logic [13:0] LEN5_MASK = 14'h07FF;

  // run length saturates here; longer runs matter to no counter
  localparam logic [2:0] RUN_SAT = 3'h6;

  //////////////////////////////////////////////////////////////////////////////
  // types
  typedef struct packed {
    logic [13:0] rng;  // range field
    logic [13:0] max;  // maximum field
  } erc_limit_type;

  typedef struct packed {
    logic start;    // begin a new sample window
    logic valid;    // bit_val is a sample
    logic bit_val;  // entropy sample
    logic last;     // this sample closes the window
  } erc_sample_type;

  typedef enum {ERC_IDLE, ERC_COLLECT, ERC_JUDGE} erc_state_type;

endpackage

// ### verilog/erc_top.sv
// Purpose: run-length statistical check on an entropy sample window
// Assumes: samples come from logic on mclk; retries are rerun by the caller
// Notes:   counts of lengths 3 to 5, limits and verdict reached over a plain register port
`timescale 1ns/100ps

module erc_top
  import erc_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        arst_n,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // entropy samples
  input  wire erc_sample_type samp,
  // verdict
  output logic             check_pass,
  output logic             retry_req,
  output logic             gen_error,
  output logic             busy
);

  //////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [13:0] len_mask(input int len);
    unique case (len)
      2:       len_mask = LEN2_MASK;
      3:       len_mask = LEN3_MASK;
      4:       len_mask = LEN4_MASK;
      default: len_mask = LEN5_MASK;
    endcase
  endfunction

  function automatic erc_limit_type reset_limit(input int len);
    unique case (len)
      2:       reset_limit = '{LEN2_RNG_RST, LEN2_MAX_RST};
      3:       reset_limit = '{LEN3_RNG_RST, LEN3_MAX_RST};
      4:       reset_limit = '{LEN4_RNG_RST, LEN4_MAX_RST};
      default: reset_limit = '{LEN5_RNG_RST, LEN5_MAX_RST};
    endcase
  endfunction

  function automatic erc_limit_type disable_limit(input int len);
    unique case (len)
      2:       disable_limit = '{LEN2_RNG_DIS, LEN2_MAX_DIS};
      3:       disable_limit = '{LEN3_RNG_DIS, LEN3_MAX_DIS};
      4:       disable_limit = '{LEN4_RNG_DIS, LEN4_MAX_DIS};
      default: disable_limit = '{LEN5_RNG_DIS, LEN5_MAX_DIS};
    endcase
  endfunction

  // runs seen = (max - ones) + (max - zeros); pass if max-rng < runs < max
  function automatic logic window_ok(input erc_limit_type lim,
                                     input logic [13:0] c1,
                                     input logic [13:0] c0);
    logic signed [16:0] runs;
    logic signed [16:0] low;
    runs = 17'(lim.max) - 17'(c1) + 17'(lim.max) - 17'(c0);
    low  = 17'(lim.max) - 17'(lim.rng);
    window_ok = (runs < $signed(17'(lim.max))) && (runs > low);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // state
  erc_state_type      state;           // sequencer
  logic               program_mode_select;            // program_mode_select
  logic               dis_st;          // self_test_disable
  logic [3:0]         retries;         // retries_remaining
  erc_limit_type      lim  [2:5];      // limits per run length
  logic [13:0]        cnt1 [2:5];      // ones-run down-counters
  logic [13:0]        cnt0 [2:5];      // zeros-run down-counters
  logic [3:0]         fail_flags;      // last verdict per length 2..5
  logic               prev_bit;        // value of the current run
  logic [2:0]         run_len;         // length of the current run
  logic               left_bound;      // current run began after an opposite bit
  logic               first_pending;   // next sample is the window's first
  logic               run_hit;         // a bounded run ended this cycle
  logic [2:0]         hit_len;         // its length
  logic               hit_val;         // its bit value
  logic [3:0]         pass_vec;        // per-length verdict
  logic               wr_ctl;          // write to main_control
  logic               lim_wr_ok;       // limit writes allowed

  assign wr_ctl    = reg_wr && (reg_addr == MAIN_CONTROL_OFS);
  assign lim_wr_ok = reg_wr && program_mode_select;

  //////////////////////////////////////////////////////////////////////////////
  // control bits and retry count
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      program_mode_select    <= 1'b0;
      dis_st  <= 1'b0;
      retries <= RETRY_RST;
    end else begin
      if (wr_ctl) begin
        program_mode_select   <= reg_wdata[PROGRAM_MODE_SELECT_BIT];
        dis_st <= reg_wdata[DIS_ST_BIT];
      end
      // a failing verdict consumes a retry; it wins over a software write
      if (state == ERC_JUDGE && pass_vec != 4'hF && retries != 4'h0) begin
        retries <= retries - 4'h1;
      end else if (reg_wr && reg_addr == MISC_CHECK_OFS) begin
        retries <= reg_wdata[RETRY_LSB +: 4];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // limit fields: reset, restore, self-test disable, program-mode writes
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (int l = 2; l <= 5; l++) begin
        lim[l] <= reset_limit(l);
      end
    end else begin
      for (int l = 2; l <= 5; l++) begin
        // disable takes precedence when both actions share one write
        if (wr_ctl && reg_wdata[DIS_ST_BIT]) begin
          lim[l] <= disable_limit(l);
        end else if (wr_ctl && reg_wdata[RESTORE_DEFAULTS_BIT]) begin
          lim[l] <= reset_limit(l);
        end else if (lim_wr_ok && reg_addr == RUN2_OFS + 8'(4 * (l - 2))) begin
          lim[l].rng <= reg_wdata[HI_LSB +: 14] & len_mask(l);
          lim[l].max <= reg_wdata[13:0] & len_mask(l);
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // run tracker; a run is counted only when bounded on both sides
  always_comb begin
    run_hit = 1'b0;
    hit_len = run_len;
    hit_val = prev_bit;
    // the opening run lacks a left bound, the closing one never ends here
    if (state == ERC_COLLECT && samp.valid && !first_pending
        && samp.bit_val != prev_bit && left_bound
        && run_len >= 3'h2 && run_len <= 3'h5) begin
      run_hit = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      prev_bit      <= 1'b0;
      run_len       <= 3'h0;
      left_bound    <= 1'b0;
      first_pending <= 1'b0;
    end else if (samp.start) begin
      first_pending <= 1'b1;
      left_bound    <= 1'b0;
      run_len       <= 3'h0;
    end else if (state == ERC_COLLECT && samp.valid) begin
      first_pending <= 1'b0;
      if (first_pending) begin
        prev_bit   <= samp.bit_val;
        run_len    <= 3'h1;
        left_bound <= 1'b0;
      end else if (samp.bit_val == prev_bit) begin
        run_len <= (run_len == RUN_SAT) ? RUN_SAT : run_len + 3'h1;
      end else begin
        prev_bit   <= samp.bit_val;
        run_len    <= 3'h1;
        left_bound <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // down-counters; they stop at zero rather than wrap to a large count
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (int l = 2; l <= 5; l++) begin
        cnt1[l] <= 14'h0000;
        cnt0[l] <= 14'h0000;
      end
    end else if (samp.start) begin
      for (int l = 2; l <= 5; l++) begin
        cnt1[l] <= lim[l].max;
        cnt0[l] <= lim[l].max;
      end
    end else if (run_hit) begin
      for (int l = 2; l <= 5; l++) begin
        if (hit_len == 3'(l) && hit_val && cnt1[l] != 14'h0000) begin
          cnt1[l] <= cnt1[l] - 14'h0001;
        end
        if (hit_len == 3'(l) && !hit_val && cnt0[l] != 14'h0000) begin
          cnt0[l] <= cnt0[l] - 14'h0001;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // verdict per length
  always_comb begin
    for (int l = 2; l <= 5; l++) begin
      pass_vec[l - 2] = window_ok(lim[l], cnt1[l], cnt0[l]);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sequencer and verdict outputs
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state      <= ERC_IDLE;
      check_pass <= 1'b0;
      retry_req  <= 1'b0;
      gen_error  <= 1'b0;
      busy       <= 1'b0;
      fail_flags <= 4'h0;
    end else begin
      check_pass <= 1'b0;
      retry_req  <= 1'b0;
      unique case (state)
        ERC_IDLE: begin
          if (samp.start) begin
            state     <= ERC_COLLECT;
            busy      <= 1'b1;
            gen_error <= 1'b0;
          end
        end
        ERC_COLLECT: begin
          // a fresh start simply reopens the window
          if (!samp.start && samp.valid && samp.last) begin
            state <= ERC_JUDGE;
          end
        end
        ERC_JUDGE: begin
          state      <= ERC_IDLE;
          busy       <= 1'b0;
          fail_flags <= ~pass_vec;
          if (pass_vec == 4'hF) begin
            check_pass <= 1'b1;
          end else if (retries != 4'h0) begin
            retry_req <= 1'b1;
          end else begin
            gen_error <= 1'b1;
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read port; data stand for one cycle, unmapped reads return zero
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= 32'h0000_0000;
      if (reg_rd) begin
        unique case (reg_addr)
          MAIN_CONTROL_OFS: begin
            reg_rdata[PROGRAM_MODE_SELECT_BIT]   <= program_mode_select;
            reg_rdata[DIS_ST_BIT] <= dis_st;
          end
          MISC_CHECK_OFS: reg_rdata[RETRY_LSB +: 4] <= retries;
          CHECK_RESULT_OFS: reg_rdata <= {24'h00_0000, busy, gen_error, 2'h0, fail_flags};
          RUN2_OFS: begin
            // length-2 counts are not held here; the offset reads zero then
            if (program_mode_select) reg_rdata <= {2'h0, lim[2].rng, 2'h0, lim[2].max};
          end
          RUN3_OFS: begin
            if (program_mode_select) reg_rdata <= {2'h0, lim[3].rng, 2'h0, lim[3].max};
            else      reg_rdata <= {2'h0, cnt1[3], 2'h0, cnt0[3]};
          end
          RUN4_OFS: begin
            if (program_mode_select) reg_rdata <= {2'h0, lim[4].rng, 2'h0, lim[4].max};
            else      reg_rdata <= {2'h0, cnt1[4], 2'h0, cnt0[4]};
          end
          RUN5_OFS: begin
            if (program_mode_select) reg_rdata <= {2'h0, lim[5].rng, 2'h0, lim[5].max};
            else      reg_rdata <= {2'h0, cnt1[5], 2'h0, cnt0[5]};
          end
          default: reg_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  a_len2_disable: assert property (
    wr_ctl && reg_wdata[DIS_ST_BIT] |=> lim[2] == {LEN2_RNG_DIS, LEN2_MAX_DIS})
    else $error("length-2 limits not loaded on self-test disable");
  a_len3_disable: assert property (
    wr_ctl && reg_wdata[DIS_ST_BIT] |=> lim[3] == {LEN3_RNG_DIS, LEN3_MAX_DIS})
    else $error("length-3 limits not loaded on self-test disable");
  a_len4_disable: assert property (
    wr_ctl && reg_wdata[DIS_ST_BIT] |=> lim[4] == {LEN4_RNG_DIS, LEN4_MAX_DIS})
    else $error("length-4 limits not loaded on self-test disable");
  a_restore_def: assert property (
    wr_ctl && reg_wdata[RESTORE_DEFAULTS_BIT] && !reg_wdata[DIS_ST_BIT]
    |=> lim[3] == {LEN3_RNG_RST, LEN3_MAX_RST} && lim[5] == {LEN5_RNG_RST, LEN5_MAX_RST})
    else $error("limits not restored to reset values");
  a_ro_ignored: assert property (
    reg_wr && !program_mode_select && reg_addr == RUN3_OFS |=> $stable(lim[3]))
    else $error("length-3 limits changed outside program mode");
  a_len3_ones: assert property (
    run_hit && !samp.start && hit_len == 3'h3 && hit_val && cnt1[3] != 14'h0000
    |=> cnt1[3] == $past(cnt1[3]) - 14'h0001)
    else $error("length-3 ones counter missed a run");
  a_edge_run: assert property (
    first_pending |-> !run_hit)
    else $error("run at window start was counted");
  a_retry_dec: assert property (
    state == ERC_JUDGE && pass_vec != 4'hF && retries != 4'h0
    |=> retry_req && retries == $past(retries) - 4'h1 && !gen_error)
    else $error("retry not issued or count not decremented");
  a_error_zero: assert property (
    state == ERC_JUDGE && pass_vec != 4'hF && retries == 4'h0
    |=> gen_error && !retry_req ##1 gen_error)
    else $error("exhausted retries did not raise error");
  a_count_read: assert property (
    reg_rd && !program_mode_select && reg_addr == RUN3_OFS
    |=> reg_rdata == {2'h0, $past(cnt1[3]), 2'h0, $past(cnt0[3])} ##1 reg_rdata == 32'h0 || $past(reg_rd))
    else $error("length-3 counts not returned one cycle after read");

  c_pass:  cover property (state == ERC_JUDGE ##1 check_pass);
  c_retry: cover property (retry_req);
  c_error: cover property ($rose(gen_error));
  c_len5:  cover property (run_hit && hit_len == 3'h5);

endmodule
